// ==== logic/sequence_pkg.sv ====
package sequence_pkg;
  // ************************************************************
  // geometry and limits
  // ************************************************************
  localparam int SLOTS = 10;
  localparam int STAGES = 150;
  localparam int MIN_TOTAL = 2;
  localparam int MAX_LOOPS = 50000;
  localparam int AMPS_W = 16;
  localparam int HOLD_W = 21;
  localparam int MEM_AW = 11;
  localparam int MEM_DEPTH = (SLOTS + 1) * STAGES;
  // hold time is kept in milliseconds: 0.010 s .. 2000 s
  localparam int HOLD_MIN_MS = 10;
  localparam int HOLD_MAX_MS = 2000000;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_SLOT = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_CHAIN = 8'h08;
  localparam logic [7:0] OFF_LOOPS = 8'h0c;
  localparam logic [7:0] OFF_RUN = 8'h10;
  localparam logic [7:0] OFF_STAGE = 8'h14;
  localparam logic [7:0] OFF_AMPS = 8'h18;
  localparam logic [7:0] OFF_HOLD = 8'h1c;
  localparam logic [7:0] OFF_TOTAL = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // command register bit positions
  localparam int CMD_ERASE_BIT = 0;
  localparam int CMD_ALL_BIT = 1;
  localparam int CMD_STORE_BIT = 2;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] RST_SLOT = 4'h1;
  localparam logic [3:0] RST_CHAIN = 4'h0;
  localparam logic [15:0] RST_LOOPS = 16'h0001;
  localparam logic [7:0] RST_STAGE = 8'h01;
  localparam logic [7:0] RST_TOTAL = 8'h02;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_NS = 8;
  localparam int HOLD_UNIT_NS = 1000000;
  localparam int TICK_CYCLES = HOLD_UNIT_NS / CLOCK_NS;
  localparam int TICK_W = 17;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [2:0] {ph_idle, ph_copy, ph_fetch, ph_load, ph_hold} phase_t;

  typedef struct packed {
    logic [7:0] total;
    logic [15:0] loops;
    logic [3:0] chain;
  } hdr_t;

  typedef struct packed {
    phase_t ph;
    wb_rsp_t rsp;
    logic pend;
    logic pend_hold;
    logic [3:0] slot;
    logic [3:0] chain;
    logic [15:0] loops;
    logic [7:0] stage_sel;
    logic [7:0] total;
    hdr_t [SLOTS-1:0] hdr;
    logic erase;
    logic all;
    logic [3:0] c_area;
    logic [7:0] cnt;
    logic wv;
    logic [3:0] w_area;
    logic [7:0] widx;
    logic active;
    logic [3:0] r_slot;
    logic [7:0] r_stage;
    logic [15:0] r_done;
    logic [HOLD_W-1:0] hold_left;
    logic [TICK_W-1:0] tick;
    logic [AMPS_W-1:0] level;
  } state_t;
endpackage

// ==== logic/sequence_program_store.sv ====
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module sequence_program_store #(
  parameter int TICK_CYCLES = sequence_pkg::TICK_CYCLES,
  parameter logic [15:0] AMPS_MAX = 16'hffff
) (
  input wire logic clock,
  input wire logic rst,
  input wire sequence_pkg::wb_req_t bus_req,
  output sequence_pkg::wb_rsp_t bus_rsp,
  output logic [sequence_pkg::AMPS_W-1:0] stage_amperage_out,
  output logic sequence_active
);
  // ************************************************************
  // storage
  // ************************************************************
  sequence_pkg::state_t q;
  sequence_pkg::state_t n;
  sequence_pkg::hdr_t cur_hdr;
  sequence_pkg::hdr_t chain_hdr;
  logic take;
  logic wr_ok;
  logic ms_tick;
  logic fin_chain;
  logic [7:0] off;
  logic [31:0] rdv;
  logic we_a;
  logic we_h;
  logic [sequence_pkg::MEM_AW-1:0] wa;
  logic [sequence_pkg::MEM_AW-1:0] ra;
  logic [sequence_pkg::AMPS_W-1:0] amps_wd;
  logic [sequence_pkg::AMPS_W-1:0] amps_rd;
  logic [sequence_pkg::HOLD_W-1:0] hold_wd;
  logic [sequence_pkg::HOLD_W-1:0] hold_rd;

  // area 0 is the edit buffer, areas 1..10 are the stored slots
  function automatic logic [sequence_pkg::MEM_AW-1:0] maddr(
    input logic [3:0] area,
    input logic [7:0] idx
  );
    return sequence_pkg::MEM_AW'(sequence_pkg::MEM_AW'(area) *
      sequence_pkg::MEM_AW'(sequence_pkg::STAGES) + sequence_pkg::MEM_AW'(idx));
  endfunction
  stage_bank #(.WIDTH(sequence_pkg::AMPS_W), .DEPTH(sequence_pkg::MEM_DEPTH),
    .AW(sequence_pkg::MEM_AW)) amps_bank (
    .clock(clock), .we(we_a), .wa(wa), .wd(amps_wd), .ra(ra), .rd(amps_rd)
  );
  stage_bank #(.WIDTH(sequence_pkg::HOLD_W), .DEPTH(sequence_pkg::MEM_DEPTH),
    .AW(sequence_pkg::MEM_AW)) hold_bank (
    .clock(clock), .we(we_h), .wa(wa), .wd(hold_wd), .ra(ra), .rd(hold_rd)
  );

  // ************************************************************
  // bus decode
  // ************************************************************
  // copy and fetch own the read port, so the bus waits through them
  assign take = bus_req.cyc && bus_req.stb && !q.rsp.ack && !q.pend &&
    q.ph != sequence_pkg::ph_copy && q.ph != sequence_pkg::ph_fetch;
  // only full-word writes are honoured
  assign wr_ok = take && bus_req.we && bus_req.sel == 4'hf;
  assign off = {bus_req.adr[7:2], 2'b00};
  assign cur_hdr = q.hdr[q.r_slot - 4'h1];
  assign chain_hdr = q.hdr[cur_hdr.chain - 4'h1];
  assign ms_tick = q.tick == sequence_pkg::TICK_W'(TICK_CYCLES - 1);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n = q;
    n.rsp.ack = 1'b0;
    fin_chain = 1'b0;
    we_a = 1'b0;
    we_h = 1'b0;
    wa = maddr(4'h0, q.stage_sel - 8'h01);
    ra = maddr(4'h0, q.stage_sel - 8'h01);
    amps_wd = bus_req.dat[sequence_pkg::AMPS_W-1:0];
    hold_wd = bus_req.dat[sequence_pkg::HOLD_W-1:0];
    case (off)
      sequence_pkg::OFF_SLOT: rdv = 32'(q.slot);
      sequence_pkg::OFF_CHAIN: rdv = 32'(q.chain);
      sequence_pkg::OFF_LOOPS: rdv = 32'(q.loops);
      sequence_pkg::OFF_RUN: rdv = 32'(q.active);
      sequence_pkg::OFF_STAGE: rdv = 32'(q.stage_sel);
      sequence_pkg::OFF_TOTAL: rdv = 32'(q.total);
      sequence_pkg::OFF_STATUS: rdv = {q.r_done, q.r_stage, q.r_slot, 3'h0, q.active};
      default: rdv = 32'h0;
    endcase

    // copy engine: save reads area 0 and writes one cycle later
    if (q.ph == sequence_pkg::ph_copy) begin
      ra = maddr(4'h0, q.cnt);
      if (q.wv) begin
        we_a = 1'b1;
        we_h = 1'b1;
        wa = maddr(q.w_area, q.widx);
        amps_wd = q.erase ? '0 : amps_rd;
        hold_wd = q.erase ? '0 : hold_rd;
      end
      n.wv = q.cnt < 8'(sequence_pkg::STAGES);
      n.widx = q.cnt;
      n.w_area = q.c_area;
      if (q.cnt < 8'(sequence_pkg::STAGES - 1)) begin
        n.cnt = q.cnt + 8'h01;
      end else if (q.cnt == 8'(sequence_pkg::STAGES - 1)) begin
        if (q.all && q.c_area != 4'(sequence_pkg::SLOTS)) begin
          n.cnt = 8'h00;
          n.c_area = q.c_area + 4'h1;
        end else begin
          n.cnt = 8'(sequence_pkg::STAGES);
        end
      end else begin
        n.ph = sequence_pkg::ph_idle;
      end
    end

    // run engine
    case (q.ph)
      sequence_pkg::ph_fetch: begin
        ra = maddr(q.r_slot, q.r_stage - 8'h01);
        n.ph = sequence_pkg::ph_load;
      end
      sequence_pkg::ph_load: begin
        n.level = amps_rd;
        n.hold_left = hold_rd;
        n.tick = '0;
        n.ph = sequence_pkg::ph_hold;
      end
      sequence_pkg::ph_hold: begin
        n.tick = ms_tick ? '0 : q.tick + 1'b1;
        if (q.hold_left != '0) begin
          if (ms_tick) begin
            n.hold_left = q.hold_left - 1'b1;
          end
        end else if (q.r_stage < cur_hdr.total) begin
          n.r_stage = q.r_stage + 8'h01;
          n.ph = sequence_pkg::ph_fetch;
        end else if (q.r_done + 16'h0001 < cur_hdr.loops) begin
          n.r_done = q.r_done + 16'h0001;
          n.r_stage = 8'h01;
          n.ph = sequence_pkg::ph_fetch;
        end else if (cur_hdr.chain != 4'h0 && chain_hdr.total != 8'h00) begin
          fin_chain = 1'b1;
          n.r_slot = cur_hdr.chain;
          n.r_stage = 8'h01;
          n.r_done = 16'h0000;
          n.ph = sequence_pkg::ph_fetch;
        end else begin
          n.ph = sequence_pkg::ph_idle;
          n.active = 1'b0;
          n.level = '0;
        end
      end
      default: ;
    endcase

    // bus slave; a stop written here wins over the run engine
    if (q.pend) begin
      n.pend = 1'b0;
      n.rsp.ack = 1'b1;
      n.rsp.dat = q.pend_hold ? 32'(hold_rd) : 32'(amps_rd);
    end else if (take) begin
      if (!bus_req.we && (off == sequence_pkg::OFF_AMPS || off == sequence_pkg::OFF_HOLD)) begin
        n.pend = 1'b1;
        n.pend_hold = off == sequence_pkg::OFF_HOLD;
      end else begin
        n.rsp.ack = 1'b1;
        n.rsp.dat = bus_req.we ? 32'h0 : rdv;
      end
    end
    if (wr_ok) begin
      case (off)
        sequence_pkg::OFF_SLOT: begin
          if (bus_req.dat != 32'h0 && bus_req.dat <= 32'(sequence_pkg::SLOTS)) begin
            n.slot = bus_req.dat[3:0];
          end
        end
        sequence_pkg::OFF_CHAIN: begin
          if (bus_req.dat <= 32'(sequence_pkg::SLOTS)) begin
            n.chain = bus_req.dat[3:0];
          end
        end
        sequence_pkg::OFF_LOOPS: begin
          if (bus_req.dat != 32'h0 && bus_req.dat <= 32'(sequence_pkg::MAX_LOOPS)) begin
            n.loops = bus_req.dat[15:0];
          end
        end
        sequence_pkg::OFF_STAGE: begin
          if (bus_req.dat != 32'h0 && bus_req.dat <= 32'(sequence_pkg::STAGES)) begin
            n.stage_sel = bus_req.dat[7:0];
          end
        end
        sequence_pkg::OFF_TOTAL: begin
          if (bus_req.dat >= 32'(sequence_pkg::MIN_TOTAL) &&
              bus_req.dat <= 32'(sequence_pkg::STAGES)) begin
            n.total = bus_req.dat[7:0];
          end
        end
        sequence_pkg::OFF_AMPS: we_a = bus_req.dat <= 32'(AMPS_MAX);
        sequence_pkg::OFF_HOLD: we_h = bus_req.dat >= 32'(sequence_pkg::HOLD_MIN_MS) &&
          bus_req.dat <= 32'(sequence_pkg::HOLD_MAX_MS);
        sequence_pkg::OFF_RUN: begin
          if (bus_req.dat == 32'h1 && q.ph == sequence_pkg::ph_idle &&
              q.hdr[q.slot - 4'h1].total != 8'h00) begin
            n.active = 1'b1;
            n.r_slot = q.slot;
            n.r_stage = 8'h01;
            n.r_done = 16'h0000;
            n.ph = sequence_pkg::ph_fetch;
          end else if (bus_req.dat == 32'h0 && q.active) begin
            n.active = 1'b0;
            n.level = '0;
            n.ph = sequence_pkg::ph_idle;
          end
        end
        sequence_pkg::OFF_CMD: begin
          // slot contents cannot change under a running sequence
          if (!q.active && bus_req.dat[2:0] != 3'h0) begin
            n.ph = sequence_pkg::ph_copy;
            n.cnt = 8'h00;
            n.wv = 1'b0;
            n.all = bus_req.dat[sequence_pkg::CMD_ALL_BIT];
            n.erase = !(bus_req.dat[sequence_pkg::CMD_STORE_BIT] &&
              bus_req.dat[1:0] == 2'h0);
            n.c_area = bus_req.dat[sequence_pkg::CMD_ALL_BIT] ? 4'h1 : q.slot;
            if (bus_req.dat[sequence_pkg::CMD_ALL_BIT]) begin
              for (int i = 0; i < sequence_pkg::SLOTS; i++) begin
                n.hdr[i].total = 8'h00;
              end
            end else if (bus_req.dat[sequence_pkg::CMD_ERASE_BIT]) begin
              n.hdr[q.slot - 4'h1].total = 8'h00;
            end else begin
              n.hdr[q.slot - 4'h1] = '{q.total, q.loops, q.chain};
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ph <= sequence_pkg::ph_idle;
      q.slot <= sequence_pkg::RST_SLOT;
      q.chain <= sequence_pkg::RST_CHAIN;
      q.loops <= sequence_pkg::RST_LOOPS;
      q.stage_sel <= sequence_pkg::RST_STAGE;
      q.total <= sequence_pkg::RST_TOTAL;
    end else begin
      q <= n;
    end
  end

  assign bus_rsp = q.rsp;
  assign stage_amperage_out = q.level;
  assign sequence_active = q.active;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_slot_range: assert property (
    q.slot >= 4'h1 && q.slot <= 4'(sequence_pkg::SLOTS))
    else $error("selected slot out of range");
  chk_erase_area: assert property (
    q.ph == sequence_pkg::ph_copy && q.wv && !q.all |-> we_a && q.w_area == q.slot)
    else $error("slot erase or store wrote outside the selected slot");
  chk_erase_zero: assert property (
    q.ph == sequence_pkg::ph_copy && q.wv && q.erase |-> amps_wd == '0 && hold_wd == '0)
    else $error("erase wrote nonzero stage data");
  chk_chain_range: assert property (
    q.chain <= 4'(sequence_pkg::SLOTS))
    else $error("chain target out of range");
  chk_chain_jump: assert property (
    fin_chain |=> q.r_slot == $past(cur_hdr.chain) && q.r_stage == 8'h01 &&
      q.ph == sequence_pkg::ph_fetch)
    else $error("chained slot not started");
  chk_loops_range: assert property (
    q.loops != 16'h0 && q.loops <= 16'(sequence_pkg::MAX_LOOPS))
    else $error("loop count out of range");
  chk_run_start: assert property (
    wr_ok && off == sequence_pkg::OFF_RUN && bus_req.dat == 32'h1 &&
      q.ph == sequence_pkg::ph_idle && q.hdr[q.slot - 4'h1].total != 8'h00
      |=> q.active && q.ph == sequence_pkg::ph_fetch ##1 q.ph == sequence_pkg::ph_load)
    else $error("execution enable did not start the sequence");
  chk_run_query: assert property (
    take && !bus_req.we && off == sequence_pkg::OFF_RUN
      |=> bus_rsp.ack && bus_rsp.dat == 32'($past(q.active)))
    else $error("execution query answered wrong state");
  chk_store_data: assert property (
    q.ph == sequence_pkg::ph_copy && q.wv && !q.erase |-> amps_wd == amps_rd && we_h)
    else $error("store did not copy edited data");
  chk_stage_range: assert property (
    q.stage_sel != 8'h0 && q.stage_sel <= 8'(sequence_pkg::STAGES))
    else $error("stage index out of range");
  chk_amps_readback: assert property (
    take && !bus_req.we && off == sequence_pkg::OFF_AMPS |=> !bus_rsp.ack ##1 bus_rsp.ack)
    else $error("amperage readback timing wrong");
  chk_hold_count: assert property (
    q.ph == sequence_pkg::ph_hold && q.hold_left != '0 && !ms_tick
      |=> q.ph != sequence_pkg::ph_hold || q.hold_left == $past(q.hold_left))
    else $error("hold time moved without a tick");
  chk_total_range: assert property (
    q.total >= 8'(sequence_pkg::MIN_TOTAL) && q.total <= 8'(sequence_pkg::STAGES))
    else $error("stage count out of range");
  chk_slot_reject: assert property (
    wr_ok && off == sequence_pkg::OFF_SLOT && bus_req.dat > 32'(sequence_pkg::SLOTS)
      |=> q.slot == $past(q.slot))
    else $error("out of range slot accepted");
  chk_stage_order: assert property (
    q.ph == sequence_pkg::ph_hold && n.ph == sequence_pkg::ph_fetch && !fin_chain
      |=> q.r_stage == $past(q.r_stage) + 8'h01 || q.r_stage == 8'h01)
    else $error("stages not taken in ascending order");

  cov_run: cover property (q.ph == sequence_pkg::ph_load ##1 q.ph == sequence_pkg::ph_hold);
  cov_chain: cover property (fin_chain);
  cov_store: cover property (q.ph == sequence_pkg::ph_copy && !q.erase ##1
    q.ph == sequence_pkg::ph_idle);
endmodule

// ==== logic/stage_bank.sv ====
`timescale 1ns/100ps
// one write port, one registered read port
module stage_bank #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 1650,
  parameter int AW = 11
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [WIDTH-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [WIDTH-1:0] rd
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
// ************************************************************
// remote host: classic single-cycle bus master
// ************************************************************
module host_model (
  input wire logic clock,
  output sequence_pkg::wb_req_t bus_req,
  input wire sequence_pkg::wb_rsp_t bus_rsp
);
  initial begin
    bus_req = '0;
  end

  // the request stands until ack is sampled; only the bench watchdog ends a long stall
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    bus_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do begin
      @(posedge clock);
    end while (bus_rsp.ack !== 1'b1);
    rd = bus_rsp.dat;
    // released data lines flip so a stale value is never mistaken for a live one
    bus_req.cyc <= 1'b0;
    bus_req.stb <= 1'b0;
    bus_req.dat <= ~wd;
    @(posedge clock);
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  localparam int TICKS = 4;
  logic clock;
  logic rst;
  sequence_pkg::wb_req_t bus_req;
  sequence_pkg::wb_rsp_t bus_rsp;
  logic [sequence_pkg::AMPS_W-1:0] stage_amperage_out;
  logic sequence_active;
  int error_cnt;
  int cmp_count;
  logic [31:0] rdata;
  logic [15:0] seen_q[$];
  int run_len;

  sequence_program_store #(.TICK_CYCLES(TICKS), .AMPS_MAX(16'hffff)) sequence_program_store_i (
    .clock(clock),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .stage_amperage_out(stage_amperage_out),
    .sequence_active(sequence_active)
  );

  host_model host_model_i (
    .clock(clock),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    host_model_i.xfer(1'b1, adr, d, rdata);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    host_model_i.xfer(1'b0, adr, 32'h0, rdata);
    check(name, rdata, exp);
  endtask

  task automatic set_stage(input logic [7:0] idx, input logic [15:0] amps);
    wr(sequence_pkg::OFF_STAGE, {24'h0, idx});
    wr(sequence_pkg::OFF_AMPS, {16'h0, amps});
    wr(sequence_pkg::OFF_HOLD, 32'(sequence_pkg::HOLD_MIN_MS));
  endtask

  // collects each new nonzero level while the engine runs
  task automatic record_run();
    logic [15:0] last;
    int n;
    seen_q.delete();
    last = 16'h0;
    n = 0;
    while (sequence_active !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (sequence_active === 1'b1 && n < 1000) begin
      if (stage_amperage_out !== 16'h0 && stage_amperage_out !== last) begin
        seen_q.push_back(stage_amperage_out);
        last = stage_amperage_out;
      end
      @(posedge clock);
      n++;
    end
    run_len = n;
  endtask

  task automatic run_and_compare(input logic [15:0] exp[]);
    fork
      record_run();
      begin
        wr(sequence_pkg::OFF_RUN, 32'h1);
        rd_chk("run_on", sequence_pkg::OFF_RUN, 32'h1);
      end
    join
    check("seq_len", seen_q.size(), exp.size());
    check("run_len", run_len, exp.size() * (sequence_pkg::HOLD_MIN_MS * TICKS + 3));
    foreach (exp[i]) check("seq_level", (i < seen_q.size()) ? seen_q[i] : 16'h0, exp[i]);
    rd_chk("run_off", sequence_pkg::OFF_RUN, 32'h0);
    check("out_idle", stage_amperage_out, 16'h0);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd_chk("slot", sequence_pkg::OFF_SLOT, 32'h1);
    rd_chk("chain", sequence_pkg::OFF_CHAIN, 32'h0);
    rd_chk("loops", sequence_pkg::OFF_LOOPS, 32'h1);
    rd_chk("stage", sequence_pkg::OFF_STAGE, 32'h1);
    rd_chk("total", sequence_pkg::OFF_TOTAL, 32'h2);
    rd_chk("status", sequence_pkg::OFF_STATUS, 32'h0);
    rd_chk("cmd", sequence_pkg::OFF_CMD, 32'h0);
    rd_chk("unmapped", 8'h30, 32'h0);
  endtask

  task automatic t_ranges();
    logic [7:0] adr[7];
    logic [31:0] lo[7];
    logic [31:0] hi[7];
    logic [31:0] good[7];
    adr = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h20, 8'h1c, 8'h18};
    lo = '{32'h0, 32'hb, 32'h0, 32'h0, 32'h1, 32'h9, 32'h10000};
    hi = '{32'hb, 32'hb, 32'hc351, 32'h97, 32'h97, 32'h1e8481, 32'h10000};
    good = '{32'ha, 32'ha, 32'hc350, 32'h96, 32'h96, 32'h1e8480, 32'hffff};
    for (int i = 0; i < 7; i++) begin
      wr(adr[i], good[i]);
      wr(adr[i], lo[i]);
      wr(adr[i], hi[i]);
      rd_chk("range_keep", adr[i], good[i]);
    end
  endtask

  task automatic t_run();
    set_stage(8'h3, 16'h0099);
    set_stage(8'h2, 16'h0022);
    set_stage(8'h1, 16'h0011);
    rd_chk("amps_back", sequence_pkg::OFF_AMPS, 32'h11);
    rd_chk("hold_back", sequence_pkg::OFF_HOLD, 32'(sequence_pkg::HOLD_MIN_MS));
    wr(sequence_pkg::OFF_TOTAL, 32'h2);
    wr(sequence_pkg::OFF_LOOPS, 32'h2);
    wr(sequence_pkg::OFF_CHAIN, 32'h0);
    wr(sequence_pkg::OFF_SLOT, 32'h2);
    rd_chk("slot_sel", sequence_pkg::OFF_SLOT, 32'h2);
    wr(sequence_pkg::OFF_CMD, 32'h4);
    run_and_compare('{16'h11, 16'h22, 16'h11, 16'h22});
  endtask

  task automatic t_chain();
    set_stage(8'h1, 16'h0033);
    set_stage(8'h2, 16'h0044);
    wr(sequence_pkg::OFF_LOOPS, 32'h1);
    wr(sequence_pkg::OFF_CHAIN, 32'h2);
    rd_chk("chain_set", sequence_pkg::OFF_CHAIN, 32'h2);
    wr(sequence_pkg::OFF_SLOT, 32'h3);
    wr(sequence_pkg::OFF_CMD, 32'h4);
    run_and_compare('{16'h33, 16'h44, 16'h11, 16'h22, 16'h11, 16'h22});
  endtask

  task automatic t_erase();
    wr(sequence_pkg::OFF_CMD, 32'h1);
    wr(sequence_pkg::OFF_RUN, 32'h1);
    rd_chk("erased_slot", sequence_pkg::OFF_RUN, 32'h0);
    wr(sequence_pkg::OFF_SLOT, 32'h2);
    wr(sequence_pkg::OFF_RUN, 32'h1);
    // erase while running must be ignored, so slot 2 keeps its contents
    wr(sequence_pkg::OFF_CMD, 32'h2);
    check("active", sequence_active, 1'b1);
    wr(sequence_pkg::OFF_RUN, 32'h0);
    check("stopped", sequence_active, 1'b0);
    run_and_compare('{16'h11, 16'h22, 16'h11, 16'h22});
    wr(sequence_pkg::OFF_CMD, 32'h2);
    wr(sequence_pkg::OFF_RUN, 32'h1);
    rd_chk("all_erased", sequence_pkg::OFF_RUN, 32'h0);
  endtask

  // ************************************************************
  // verdict and sequencing
  // ************************************************************
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    // the longest scenario stalls ~1500 cycles on an erase copy; this leaves ample margin
    repeat (40000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_ranges();
    t_run();
    t_chain();
    t_erase();
    end_sim();
  end
endmodule
